// ==== rtl/ioc_cell.sv ====
/*
 Configurable pad cell: input path with optional register and delay,
 output and three-state paths with optional registers, polarity
 control, pulls, keeper and pre-configuration pad behaviour.
 Assumes the pad and the mode inputs come from pins, every other user
 input from logic on sys_clk_i, and the board resolves the pad from
 pad_o/pad_oe_o and the weak pull and keeper outputs.
*/
`include "ioc_defs.svh"
`default_nettype none
module ioc_cell (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [`IOC_AW-1:0] addr_i,
   input wire logic [`IOC_DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`IOC_DW-1:0] rdata_o,
   input wire logic mode_pullup_i,
   input wire logic cell_clk_i,
   input wire logic [`IOC_NREG-1:0] cell_ce_i,
   input wire logic shared_set_reset_i,
   input wire logic out_data_i,
   input wire logic ts_ctrl_i,
   output logic in_data_o,
   input wire logic pad_i,
   output logic pad_o,
   output logic pad_oe_o,
   output logic pull_up_o,
   output logic pull_down_o,
   output logic keep_o,
   output logic keep_oe_o
);
   import ioc_pkg::*;

   // Pick the set/reset mode field of one register slot
   function automatic ioc_srmode_t sr_mode_of(
      input logic [`IOC_DW-1:0] m,
      input int i
   );
      return ioc_srmode_t'(m[`IOC_MODE_SR_LSB + 2*i +: 2]);
   endfunction

   // Address compare shared by write and read decode
   function automatic logic hit(
      input logic [`IOC_AW-1:0] a,
      input logic [`IOC_AW-1:0] off
   );
      return a == off;
   endfunction

   logic [`IOC_DW-1:0] ctrl_q;
   logic [`IOC_DW-1:0] mode_q;
   logic [`IOC_DW-1:0] path_q;
   logic [`IOC_DW-1:0] pol_q;
   logic pad_s;
   logic mode_pu_s;
   logic clk_prev_q;
   logic dly_q;
   logic [`IOC_NREG-1:0] st_d;
   logic [`IOC_NREG-1:0] st_q;
   logic [`IOC_NREG-1:0] ce_eff;

   // Pins cross into the clock domain first
   ioc_sync2 u_pad_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .async_i(pad_i),
      .sync_o(pad_s)
   );
   ioc_sync2 u_mode_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .async_i(mode_pullup_i),
      .sync_o(mode_pu_s)
   );

   // Register decode
   wire wr_ctrl = wr_i && hit(addr_i, `IOC_OFF_CTRL);
   wire wr_mode = wr_i && hit(addr_i, `IOC_OFF_MODE);
   wire wr_path = wr_i && hit(addr_i, `IOC_OFF_PATH);
   wire wr_pol = wr_i && hit(addr_i, `IOC_OFF_POL);
   wire cfg_done = ctrl_q[`IOC_CTRL_DONE];

   // Software-owned configuration words
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= `IOC_RST_WORD;
         mode_q <= `IOC_RST_WORD;
         path_q <= `IOC_RST_WORD;
         pol_q <= `IOC_RST_WORD;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= wdata_i;
         if (wr_mode)
            mode_q <= wdata_i;
         if (wr_path)
            path_q <= wdata_i;
         if (wr_pol)
            pol_q <= wdata_i;
      end
   end

   // Polarity-corrected control signals
   wire clk_eff = cell_clk_i ^ pol_q[`IOC_POL_CLK];
   wire sr_eff = shared_set_reset_i ^ pol_q[`IOC_POL_SR];
   wire clk_rise = clk_eff && !clk_prev_q;
   assign ce_eff = cell_ce_i ^
      pol_q[`IOC_POL_CE_LSB +: `IOC_NREG];

   // Input buffer and delay element
   wire pad_eff = pad_s ^ pol_q[`IOC_POL_IN];
   // Delay stage holds pad data one sys_clk cycle, while the clock edge detect adds none,
   // so data moving with the cell clock is never caught too early
   wire in_reg_d = path_q[`IOC_PATH_IN_DLY] ? dly_q : pad_eff;

   always_ff @(posedge sys_clk_i)
   begin
      clk_prev_q <= rst_i ? 1'b0 : clk_eff;
      dly_q <= rst_i ? 1'b0 : pad_eff;
   end

   // Data into the three registers
   assign st_d[`IOC_R_IN] = in_reg_d;
   assign st_d[`IOC_R_OUT] = out_data_i;
   assign st_d[`IOC_R_TS] = ts_ctrl_i;

   // Three registers on one cell clock and one set/reset
   genvar g;
   generate
      for (g = 0; g < `IOC_NREG; g++)
      begin : g_st
         ioc_storage u_st (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .latch_i(mode_q[`IOC_MODE_LATCH_LSB + g]),
            .sr_mode_i(sr_mode_of(mode_q, g)),
            .clk_rise_i(clk_rise),
            .clk_lvl_i(clk_eff),
            .ce_i(ce_eff[g]),
            .sr_i(sr_eff),
            .d_i(st_d[g]),
            .q_o(st_q[g])
         );
      end
   endgenerate

   // Path selection
   wire in_d = path_q[`IOC_PATH_IN_REG] ?
      st_q[`IOC_R_IN] : pad_eff;
   wire out_sel = path_q[`IOC_PATH_OUT_REG] ?
      st_q[`IOC_R_OUT] : out_data_i;
   wire pad_d = out_sel ^ pol_q[`IOC_POL_OUT];
   wire ts_sel = path_q[`IOC_PATH_TS_REG] ?
      st_q[`IOC_R_TS] : ts_ctrl_i;
   // High three-state control turns the driver off
   wire ts_eff = ts_sel ^ pol_q[`IOC_POL_TS];
   wire oe_d = cfg_done && !ts_eff;

   // Pulls and keeper; before configuration only the global pull-up
   wire pu_d = cfg_done ? path_q[`IOC_PATH_PU] : mode_pu_s;
   wire pd_d = cfg_done && path_q[`IOC_PATH_PD];
   wire keep_en_d = cfg_done && path_q[`IOC_PATH_KEEP] && !oe_d;

   // Pad-side outputs, all registered
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         in_data_o <= 1'b0;
         pad_o <= 1'b0;
         pad_oe_o <= 1'b0;
         pull_up_o <= 1'b0;
         pull_down_o <= 1'b0;
         keep_o <= 1'b0;
         keep_oe_o <= 1'b0;
      end
      else
      begin
         in_data_o <= in_d;
         pad_o <= pad_d;
         pad_oe_o <= oe_d;
         pull_up_o <= pu_d;
         pull_down_o <= pd_d;
         keep_o <= pad_s;
         keep_oe_o <= keep_en_d;
      end
   end

   // Status word and read mux; unmapped addresses read zero
   wire [`IOC_DW-1:0] stat_w =
      (`IOC_DW'(st_q) << `IOC_STAT_Q_LSB) |
      (`IOC_DW'(mode_pu_s) << `IOC_STAT_PU) |
      (`IOC_DW'(pad_s) << `IOC_STAT_PAD) |
      (`IOC_DW'(cfg_done) << `IOC_STAT_DONE);
   wire [`IOC_DW-1:0] rd_mux =
      hit(addr_i, `IOC_OFF_CTRL) ? ctrl_q :
      hit(addr_i, `IOC_OFF_MODE) ? mode_q :
      hit(addr_i, `IOC_OFF_PATH) ? path_q :
      hit(addr_i, `IOC_OFF_POL) ? pol_q :
      hit(addr_i, `IOC_OFF_STAT) ? stat_w : `IOC_RST_WORD;

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk_i)
   begin
      rdata_o <= (rst_i || !rd_i) ? `IOC_RST_WORD : rd_mux;
   end

   chk_precfg_hiz: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !cfg_done |=> !pad_oe_o && !pull_down_o && !keep_oe_o)
      else $error("pad not idle before configuration");
   chk_precfg_pullup: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !cfg_done |=> pull_up_o == $past(mode_pu_s))
      else $error("pre-config pull-up ignores mode input");
   chk_in_direct: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !path_q[`IOC_PATH_IN_REG] |=> in_data_o == $past(pad_eff))
      else $error("direct input path wrong");
   chk_in_delay: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      path_q[`IOC_PATH_IN_DLY] ##1 path_q[`IOC_PATH_IN_DLY]
      |-> st_d[`IOC_R_IN] == $past(pad_eff))
      else $error("input delay stage not inserted");
   chk_out_path: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      path_q[`IOC_PATH_OUT_REG]
      |=> pad_o == $past(st_q[`IOC_R_OUT] ^ pol_q[`IOC_POL_OUT]))
      else $error("registered output path wrong");
   chk_ts_reg: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cfg_done && path_q[`IOC_PATH_TS_REG] &&
      (st_q[`IOC_R_TS] == pol_q[`IOC_POL_TS]) |=> pad_oe_o)
      else $error("three-state register did not enable driver");
   chk_ts_pol: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !path_q[`IOC_PATH_TS_REG] && (ts_ctrl_i != pol_q[`IOC_POL_TS])
      |=> !pad_oe_o)
      else $error("three-state polarity not applied");
   chk_keeper: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cfg_done && path_q[`IOC_PATH_KEEP] && !oe_d
      |=> keep_oe_o && !pad_oe_o && keep_o == $past(pad_s))
      else $error("keeper not holding last level");
   chk_pull_cfg: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cfg_done |=> pull_down_o == $past(path_q[`IOC_PATH_PD]) &&
      pull_up_o == $past(path_q[`IOC_PATH_PU]))
      else $error("configured pulls not applied");

   // Direct and registered paths and their polarity, one sys_clk cycle behind the cause; undelayed input data same cycle

   chk_out_direct: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !path_q[`IOC_PATH_OUT_REG]
      |=> pad_o == $past(out_data_i ^ pol_q[`IOC_POL_OUT]))
      else $error("direct output path wrong");

   chk_oe_direct: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      cfg_done && !path_q[`IOC_PATH_TS_REG]
      |=> pad_oe_o == $past(!(ts_ctrl_i ^ pol_q[`IOC_POL_TS])))
      else $error("direct three-state path wrong");

   chk_in_reg: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      path_q[`IOC_PATH_IN_REG]
      |=> in_data_o == $past(st_q[`IOC_R_IN]))
      else $error("registered input path wrong");

   chk_in_nodly: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !path_q[`IOC_PATH_IN_DLY]
      |-> st_d[`IOC_R_IN] == pad_eff)
      else $error("input delay stage used while off");

   chk_in_pol: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !path_q[`IOC_PATH_IN_REG] && pol_q[`IOC_POL_IN]
      |=> in_data_o == $past(!pad_s))
      else $error("input polarity not applied");

   chk_out_pol: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !path_q[`IOC_PATH_OUT_REG] && pol_q[`IOC_POL_OUT]
      |=> pad_o == $past(!out_data_i))
      else $error("output polarity not applied");

   // Keeper must never fight the cell's own driver; selected pull-up is applied

   chk_keep_off: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !keep_en_d |=> !keep_oe_o)
      else $error("keeper active while not selected");

   chk_keep_yield: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      keep_oe_o |-> !pad_oe_o)
      else $error("keeper on while driver on");

   chk_pu_cfg: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      cfg_done && path_q[`IOC_PATH_PU] |=> pull_up_o)
      else $error("selected pull-up not applied");

   // Shared clock, enables and set/reset seen across the three slots

   chk_clk_once: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      clk_rise |=> !clk_rise)
      else $error("cell clock edge seen twice");

   chk_ce_indep: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !ce_eff[`IOC_R_TS] && !sr_eff |=> $stable(st_q[`IOC_R_TS]))
      else $error("three-state register moved with enable off");

   chk_sr_shared: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      sr_eff && sr_mode_of(mode_q, `IOC_R_IN) == sr_async_clear &&
      sr_mode_of(mode_q, `IOC_R_OUT) == sr_async_clear
      |=> !st_q[`IOC_R_IN] && !st_q[`IOC_R_OUT])
      else $error("shared clear missed a register");

   chk_async_preset: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      sr_eff && sr_mode_of(mode_q, `IOC_R_TS) == sr_async_preset
      |=> st_q[`IOC_R_TS])
      else $error("async preset did not act");

   chk_latch_open: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      mode_q[`IOC_MODE_LATCH_LSB + `IOC_R_OUT] && clk_eff &&
      ce_eff[`IOC_R_OUT] && !sr_eff
      |=> st_q[`IOC_R_OUT] == $past(out_data_i))
      else $error("open latch did not pass data");

   // Flip-flop ignores a steady clock level, unlike the latch
   chk_ff_edge: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !mode_q[`IOC_MODE_LATCH_LSB + `IOC_R_IN] && !clk_rise && !sr_eff
      |=> $stable(st_q[`IOC_R_IN]))
      else $error("flip-flop moved without clock edge");
endmodule
`default_nettype wire

// ==== pkg/ioc_defs.svh ====
/*
 Constants of the configurable pad cell: register offsets, field
 positions, reset values and register slot numbers.
 Assumes it is included by bare name after the package is compiled.
*/
// Contract
// - Each of the three cell registers works as flip-flop or latch.
// - One shared cell clock; every register has its own clock enable.
// - Shared set/reset, per register: sync set, sync reset, preset, clear.
// - Input, output and every control signal have own polarity inversion.
// - Before configuration outputs float; pull-down and keeper stay off.
// - Pre-configuration pull-ups are chosen globally by mode inputs.
// - Input reaches logic directly or through the input register.
// - Selectable delay ahead of input register data removes hold need.
// - Pad data comes directly or through the output register.
// - Driver enable comes directly or through the three-state register.
// - Keeper weakly holds last sensed level while all drivers are off.
// - After configuration pull-up and pull-down are selectable.
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH
`define IOC_AW 8
`define IOC_DW 32
`define IOC_NREG 3
`define IOC_R_IN 0
`define IOC_R_OUT 1
`define IOC_R_TS 2
`define IOC_OFF_CTRL 8'h00
`define IOC_OFF_MODE 8'h04
`define IOC_OFF_PATH 8'h08
`define IOC_OFF_POL 8'h0C
`define IOC_OFF_STAT 8'h10
`define IOC_RST_WORD 32'h0000_0000
`define IOC_CTRL_DONE 0
`define IOC_MODE_LATCH_LSB 0
`define IOC_MODE_SR_LSB 4
`define IOC_PATH_IN_REG 0
`define IOC_PATH_IN_DLY 1
`define IOC_PATH_OUT_REG 2
`define IOC_PATH_TS_REG 3
`define IOC_PATH_KEEP 4
`define IOC_PATH_PU 5
`define IOC_PATH_PD 6
`define IOC_POL_IN 0
`define IOC_POL_OUT 1
`define IOC_POL_TS 2
`define IOC_POL_CLK 3
`define IOC_POL_SR 4
`define IOC_POL_CE_LSB 5
`define IOC_STAT_DONE 0
`define IOC_STAT_PAD 1
`define IOC_STAT_PU 2
`define IOC_STAT_Q_LSB 4
`endif

// ==== pkg/ioc_pkg.sv ====
/*
 Types of the configurable pad cell.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package ioc_pkg;
   // Action of the shared set/reset on one register
   typedef enum logic [1:0] {
      sr_sync_set,
      sr_sync_reset,
      sr_async_preset,
      sr_async_clear
   } ioc_srmode_t;
endpackage
`default_nettype wire

// ==== rtl/ioc_sync2.sv ====
/*
 Two-flop synchroniser for one level from a pin.
 Assumes the destination clock is sys_clk_i.
*/
`default_nettype none
module ioc_sync2 (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic sync_o
);
   import ioc_pkg::*;
   logic meta_q;

   // First stage is read only by the second
   always_ff @(posedge sys_clk_i)
   begin
      meta_q <= rst_i ? 1'b0 : async_i;
      sync_o <= rst_i ? 1'b0 : meta_q;
   end
endmodule
`default_nettype wire

// ==== rtl/ioc_storage.sv ====
/*
 One storage element of the pad cell: flip-flop or latch, with the
 shared set/reset in one of four modes.
 Assumes clock edge, clock level, enable and set/reset arrive already
 polarity-corrected and on the sys_clk_i domain.
*/
`include "ioc_defs.svh"
`default_nettype none
module ioc_storage (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic latch_i,
   input wire ioc_pkg::ioc_srmode_t sr_mode_i,
   input wire logic clk_rise_i,
   input wire logic clk_lvl_i,
   input wire logic ce_i,
   input wire logic sr_i,
   input wire logic d_i,
   output logic q_o
);
   import ioc_pkg::*;
   logic q_d;
   wire is_async = (sr_mode_i == sr_async_preset) ||
                   (sr_mode_i == sr_async_clear);
   wire set_val = (sr_mode_i == sr_sync_set) ||
                  (sr_mode_i == sr_async_preset);
   // Clock event: edge for a flip-flop, open level for a latch
   wire act = latch_i ? clk_lvl_i : clk_rise_i;

   // Set/reset wins over data; sync set/reset ignores the enable
   always_comb
   begin
      q_d = q_o;
      if (sr_i && is_async)
         q_d = set_val;
      else if (sr_i && act)
         q_d = set_val;
      else if (act && ce_i)
         q_d = d_i;
   end

   always_ff @(posedge sys_clk_i)
   begin
      q_o <= rst_i ? 1'b0 : q_d;
   end

   chk_ff_capture: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !latch_i && clk_rise_i && ce_i && !sr_i |=> q_o == $past(d_i))
      else $error("flip-flop did not capture data at clock edge");
   chk_latch_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      latch_i && !clk_lvl_i && !sr_i ##1 latch_i && !clk_lvl_i && !sr_i
      |-> $stable(q_o))
      else $error("closed latch changed value");
   chk_ce_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !ce_i && !sr_i |=> q_o == $past(q_o))
      else $error("register changed with enable off");
   chk_async_now: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      sr_i && is_async |=> q_o == $past(set_val))
      else $error("async set/reset did not act at once");
   chk_sync_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      sr_i && !is_async && !act && !ce_i |=> $stable(q_o))
      else $error("sync set/reset acted without clock");
endmodule
`default_nettype wire

// ==== sim/ioc_pad_model.sv ====
/*
 Board-side model of the net on the cell's pad.
 Assumes the cell's drive, pull and keeper outputs are registered levels.
*/
`default_nettype none
module ioc_pad_model (
   input wire logic sys_clk_i,
   input wire logic drv_i,
   input wire logic drv_en_i,
   input wire logic pu_i,
   input wire logic pd_i,
   input wire logic keep_i,
   input wire logic keep_en_i,
   input wire logic ext_en_i,
   input wire logic ext_val_i,
   output logic pad_lvl_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic float_q = 1'b0;
   // A floating net toggles so that no settled value passes by luck
   always_ff @(posedge sys_clk_i)
   begin
      float_q <= ~float_q;
   end
   // Strong drivers beat the keeper, the keeper beats the pulls
   always_comb
   begin
      if (ext_en_i)
         pad_lvl_o = ext_val_i;
      else if (drv_en_i)
         pad_lvl_o = drv_i;
      else if (keep_en_i)
         pad_lvl_o = keep_i;
      else if (pu_i != pd_i)
         pad_lvl_o = pu_i;
      else
         pad_lvl_o = float_q;
   end
endmodule
`default_nettype wire

// ==== sim/configurable_io_cell_tb_top.sv ====
/*
 Self-checking bench of the pad cell with a board model on the pad.
 Assumes the cell and its package and header are compiled first.
*/
`include "ioc_defs.svh"
`default_nettype none
`define CHK(a, e) \
   begin \
      n_compared++; \
      if ((a) !== (e)) \
      begin \
         errors++; \
         $display("ERROR %0t: got %h want %h", $time, a, e); \
      end \
   end
module configurable_io_cell_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   int errors = 0;
   int n_compared = 0;
   logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [`IOC_AW-1:0] addr = '0;
   logic [`IOC_DW-1:0] wdata = '0, rdata;
   logic mode_pu = 1'b1, cell_clk = 1'b0, sr = 1'b0, out_d = 1'b0;
   logic ts = 1'b0, ext_en = 1'b0, ext_val = 1'b0;
   logic [2:0] ce = 3'h0;
   logic in_d, pad_lvl, pad_o, pad_oe, pu, pd, keep, keep_oe;
   ioc_cell DUT (.sys_clk_i(sys_clk), .rst_i(rst), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .mode_pullup_i(mode_pu), .cell_clk_i(cell_clk), .cell_ce_i(ce),
      .shared_set_reset_i(sr), .out_data_i(out_d), .ts_ctrl_i(ts),
      .in_data_o(in_d), .pad_i(pad_lvl), .pad_o(pad_o),
      .pad_oe_o(pad_oe), .pull_up_o(pu), .pull_down_o(pd),
      .keep_o(keep), .keep_oe_o(keep_oe));
   ioc_pad_model board (.sys_clk_i(sys_clk), .drv_i(pad_o),
      .drv_en_i(pad_oe), .pu_i(pu), .pd_i(pd), .keep_i(keep),
      .keep_en_i(keep_oe), .ext_en_i(ext_en), .ext_val_i(ext_val),
      .pad_lvl_o(pad_lvl));
   // 125 MHz system clock
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic finish_test;
      if (errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Let n edges land, then look between edges
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // One cell clock pulse; a flop output reaches the pad two edges on
   task automatic pulse(input logic [2:0] c);
      @(posedge sys_clk);
      ce <= c;
      cell_clk <= 1'b1;
      @(posedge sys_clk);
      cell_clk <= 1'b0;
      wt(1);
   endtask
   // Hang guard; every wait below is a fixed count anyway
   initial
   begin
      #400000;
      errors++;
      finish_test();
   end
   initial
   begin
      logic [31:0] d, w;
      logic b, e, sv;
      void'($urandom(32'hBB9E));
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      // Before configuration: driver, pull-down, keeper stay off
      bus_wr(`IOC_OFF_PATH, 32'h0000_0050);
      for (int m = 1; m >= 0; m--)
      begin
         @(posedge sys_clk);
         mode_pu <= m[0];
         wt(4);
         `CHK(pu, m[0])
         `CHK({pad_oe, pd, keep_oe}, 3'h0)
      end
      // Register read back and an unmapped place
      w = $urandom;
      bus_wr(`IOC_OFF_PATH, w);
      bus_rd(`IOC_OFF_PATH, d);
      `CHK(d, w)
      bus_rd(8'h14, d);
      `CHK(d, 32'h0)
      bus_wr(`IOC_OFF_PATH, 32'h0);
      bus_wr(`IOC_OFF_CTRL, 32'h1);
      bus_rd(`IOC_OFF_STAT, d);
      `CHK(d[`IOC_STAT_DONE], 1'b1)
      // Direct output and enable, plain and inverted
      for (int v = 0; v < 2; v++)
      begin
         bus_wr(`IOC_OFF_POL, v ? 32'h6 : 32'h0);
         repeat (6)
         begin
            @(posedge sys_clk);
            out_d <= $urandom;
            ts <= $urandom;
            wt(1);
            `CHK(pad_o, out_d ^ v[0])
            `CHK(pad_oe, ~ts ^ v[0])
         end
      end
      bus_wr(`IOC_OFF_POL, 32'h0);
      // Output flop: captures only on cell clock rise with its enable
      bus_wr(`IOC_OFF_PATH, 32'h4);
      @(posedge sys_clk);
      ts <= 1'b0;
      e = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         b = $urandom;
         @(posedge sys_clk);
         out_d <= b;
         sv = (i == 0) | $urandom;
         pulse({1'b0, sv, 1'b0});
         e = sv ? b : e;
         `CHK(pad_o, e)
      end
      // All four set/reset modes on the output register
      for (int m = 0; m < 4; m++)
      begin
         bus_wr(`IOC_OFF_MODE, m << 6);
         sv = (m == 0 || m == 2);
         @(posedge sys_clk);
         out_d <= ~sv;
         pulse(3'h2);
         @(posedge sys_clk);
         sr <= 1'b1;
         wt(3);
         `CHK(pad_o, m >= 2 ? sv : ~sv)
         pulse(3'h0);
         `CHK(pad_o, sv)
         @(posedge sys_clk);
         sr <= 1'b0;
      end
      // Output latch: transparent while clock high, holds after
      bus_wr(`IOC_OFF_MODE, 32'h2);
      @(posedge sys_clk);
      cell_clk <= 1'b1;
      ce <= 3'h2;
      for (int i = 0; i < 4; i++)
      begin
         b = $urandom;
         @(posedge sys_clk);
         out_d <= b;
         wt(2);
         `CHK(pad_o, b)
      end
      @(posedge sys_clk);
      cell_clk <= 1'b0;
      wt(2);
      @(posedge sys_clk);
      out_d <= ~b;
      wt(3);
      `CHK(pad_o, b)
      // Input path: direct, then registered behind the delay
      bus_wr(`IOC_OFF_MODE, 32'h0);
      bus_wr(`IOC_OFF_PATH, 32'h0);
      @(posedge sys_clk);
      ts <= 1'b1;
      ext_en <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         b = $urandom;
         @(posedge sys_clk);
         ext_val <= b;
         wt(3);
         `CHK(in_d, b)
      end
      // Load the input flop with the settled pad level first
      pulse(3'h1);
      bus_wr(`IOC_OFF_PATH, 32'h3);
      @(posedge sys_clk);
      ext_val <= ~b;
      wt(5);
      `CHK(in_d, b)
      pulse(3'h1);
      `CHK(in_d, ~b)
      // Keeper holds the released pad; pulls follow their bits
      bus_wr(`IOC_OFF_PATH, 32'h10);
      wt(4);
      @(posedge sys_clk);
      ext_en <= 1'b0;
      wt(6);
      `CHK({keep_oe, keep, pad_lvl}, {1'b1, ~b, ~b})
      bus_wr(`IOC_OFF_PATH, 32'h60);
      wt(2);
      `CHK({pu, pd}, 2'h3)
      finish_test();
   end
endmodule
`default_nettype wire
